// >>> hdl/bc_condition_flag_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "bc_flag_defines.svh"
module bc_condition_flag_logic (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic controller_run_enable,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic seq_valid,
  input wire bc_flag_pkg::seq_opcode_type seq_opcode,
  input wire logic [15:0] seq_operand,
  input wire logic [15:0] frame_time_count,
  input wire logic [15:0] message_time_count,
  input wire logic message_end,
  input wire logic reply_received,
  input wire logic [7:0] reply_delay_us,
  output logic [15:0] condition_code
);
  import bc_flag_pkg::*;

  logic rst_sync1;
  logic rst_n;
  logic run_pin;
  logic run_bit;
  logic [1:0] timeout_sel;
  logic next_run_bit;
  logic [1:0] next_timeout_sel;
  logic [15:0] next_condition_code;
  logic [15:0] next_reg_rdata;
  logic running;
  logic host_flag_write;
  logic [7:0] flag_set_byte;
  logic [7:0] flag_clear_byte;
  logic [7:0] gp_after_host;
  logic [15:0] compare_count;
  logic [7:0] timeout_us;

  // set, clear, toggle or keep per flag, shared by host and sequencer
  function automatic logic [7:0] apply_flags(input logic [7:0] old, input logic [15:0] op);
    logic [7:0] set_b;
    logic [7:0] clr_b;
    set_b = op[7:0];
    clr_b = op[15:8];
    apply_flags = ((old & ~clr_b) | set_b) ^ (set_b & clr_b & old);
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  pin_sync u_run_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(controller_run_enable),
    .level(run_pin)
  );

  assign running = run_pin & run_bit;
  assign flag_set_byte = reg_wdata[7:0];
  assign flag_clear_byte = reg_wdata[15:8];
  assign host_flag_write = reg_wr_en && (reg_addr == `CC_ADDR) && running;
  assign compare_count = (seq_opcode == frame_time_compare_opcode) ?
                         frame_time_count : message_time_count;

  always_comb begin
    timeout_us = `TIMEOUT0_US;
    if (timeout_sel == 2'h1) begin
      timeout_us = `TIMEOUT1_US;
    end else if (timeout_sel == 2'h2) begin
      timeout_us = `TIMEOUT2_US;
    end else if (timeout_sel == 2'h3) begin
      timeout_us = `TIMEOUT3_US;
    end
  end

  always_comb begin
    next_run_bit = run_bit;
    next_timeout_sel = timeout_sel;
    if (reg_wr_en && (reg_addr == `MASTER_CFG_ADDR)) begin
      next_run_bit = reg_wdata[`RUN_ENABLE_BIT];
    end else if (reg_wr_en && (reg_addr == `CTRL_CFG_ADDR)) begin
      next_timeout_sel = reg_wdata[`TIMEOUT_SEL_MSB:`TIMEOUT_SEL_LSB];
    end
  end

  // host change lands first, a same-cycle sequencer action then works on its result
  always_comb begin
    next_condition_code = condition_code;
    gp_after_host = condition_code[7:0];
    if (host_flag_write) begin
      gp_after_host = apply_flags(condition_code[7:0], reg_wdata);
    end
    next_condition_code[7:0] = gp_after_host;
    if (seq_valid) begin
      case (seq_opcode)
        flag_update_opcode: begin
          next_condition_code[7:0] = apply_flags(gp_after_host, seq_operand);
        end
        frame_time_compare_opcode, message_time_compare_opcode: begin
          next_condition_code[1] = (compare_count == seq_operand);
          next_condition_code[0] = (compare_count < seq_operand);
        end
        default: begin
          next_condition_code[7:0] = gp_after_host;
        end
      endcase
    end
    if (message_end) begin
      next_condition_code[`NO_REPLY_BIT] = !reply_received || (reply_delay_us > timeout_us);
    end
  end

  // condition code reads use the next word so a same-cycle write is already visible; config reads return the current register
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_rd_en && (reg_addr == `CC_ADDR)) begin
      next_reg_rdata = next_condition_code;
    end else if (reg_rd_en && (reg_addr == `MASTER_CFG_ADDR)) begin
      next_reg_rdata[`RUN_ENABLE_BIT] = run_bit;
    end else if (reg_rd_en && (reg_addr == `CTRL_CFG_ADDR)) begin
      next_reg_rdata[`TIMEOUT_SEL_MSB:`TIMEOUT_SEL_LSB] = timeout_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      condition_code <= `CC_RESET;
      reg_rdata <= 16'h0000;
      run_bit <= 1'b0;
      timeout_sel <= 2'h0;
    end else if (ce) begin
      condition_code <= next_condition_code;
      reg_rdata <= next_reg_rdata;
      run_bit <= next_run_bit;
      timeout_sel <= next_timeout_sel;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic host_only;
  logic seq_flag_only;
  logic compare_go;
  assign host_only = ce && host_flag_write && !seq_valid;
  assign seq_flag_only = ce && seq_valid && (seq_opcode == flag_update_opcode) && !host_flag_write;
  // only the two compare codes act, a malformed opcode leaves the flags alone
  assign compare_go = ce && seq_valid && ((seq_opcode == frame_time_compare_opcode)
                      || (seq_opcode == message_time_compare_opcode));

  sequence s_flag_write;
    host_only && !message_end;
  endsequence
  sequence s_read_back;
    ce && reg_rd_en && (reg_addr == `CC_ADDR) && !reg_wr_en && !seq_valid && !message_end;
  endsequence

  property p_no_reply;
    ce && message_end && !reply_received |=> condition_code[`NO_REPLY_BIT];
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("no reply flag not set");
  property p_set;
    host_only |=> ((condition_code[7:0] & $past(flag_set_byte & ~flag_clear_byte))
                   == $past(flag_set_byte & ~flag_clear_byte));
  endproperty
  a_set: assert property (p_set) else $error("flag set failed");
  property p_clear;
    host_only |=> ((condition_code[7:0] & $past(flag_clear_byte & ~flag_set_byte)) == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("flag clear failed");
  property p_toggle;
    host_only |=> (((condition_code[7:0] ^ $past(condition_code[7:0]))
                   & $past(flag_set_byte & flag_clear_byte)) == $past(flag_set_byte & flag_clear_byte));
  endproperty
  a_toggle: assert property (p_toggle) else $error("flag toggle failed");
  property p_keep;
    host_only |=> (((condition_code[7:0] ^ $past(condition_code[7:0]))
                   & $past(~flag_set_byte & ~flag_clear_byte)) == 8'h00);
  endproperty
  a_keep: assert property (p_keep) else $error("unwritten flag changed");
  property p_gated;
    ce && reg_wr_en && (reg_addr == `CC_ADDR) && !(run_pin && run_bit) && !seq_valid
      |=> condition_code[7:0] == $past(condition_code[7:0]);
  endproperty
  a_gated: assert property (p_gated) else $error("write acted while stopped");
  property p_seq_flag;
    seq_flag_only |=> condition_code[7:0] == apply_flags($past(condition_code[7:0]), $past(seq_operand));
  endproperty
  a_seq_flag: assert property (p_seq_flag) else $error("sequencer flag update wrong");
  property p_compare;
    compare_go |=> (condition_code[1] == ($past(seq_opcode == frame_time_compare_opcode) ?
                   $past(frame_time_count == seq_operand) :
                   $past(message_time_count == seq_operand)))
                   && (condition_code[0] == ($past(seq_opcode == frame_time_compare_opcode) ?
                   $past(frame_time_count < seq_operand) :
                   $past(message_time_count < seq_operand)));
  endproperty
  a_compare: assert property (p_compare) else $error("compare flags wrong");
  property p_read_after_write;
    s_flag_write ##[1:2] s_read_back |=> reg_rdata == condition_code;
  endproperty
  a_read_after_write: assert property (p_read_after_write) else $error("stale read");
endmodule
`default_nettype wire

// >>> include/bc_flag_defines.svh
// What this block does
// - late or missing reply sets no-reply flag
// - low eight flags changed by host or sequencer
// - time compares also set or clear equal flag
// - time compares also set or clear below flag
// - flag writes and word reads share one address
// - read after write shows the updated flags
// - one write changes any mix of flags
// - low byte one sets flag unless paired
// - high byte one clears flag unless paired
// - both bytes one inverts the flag
// - both bytes zero leave flag alone
// - sequencer flag update uses same encoding
// - host flag writes ignored unless controller running
`ifndef BC_FLAG_DEFINES_SVH
`define BC_FLAG_DEFINES_SVH
`define CC_ADDR 16'h0037
`define MASTER_CFG_ADDR 16'h0000
`define CTRL_CFG_ADDR 16'h0032
`define RUN_ENABLE_BIT 12
`define TIMEOUT_SEL_MSB 15
`define TIMEOUT_SEL_LSB 14
`define NO_REPLY_BIT 8
`define CC_RESET 16'h0000
`define TIMEOUT0_US 8'h0f
`define TIMEOUT1_US 8'h14
`define TIMEOUT2_US 8'h3a
`define TIMEOUT3_US 8'h8a
`endif

// >>> include/bc_flag_pkg.sv
package bc_flag_pkg;
  typedef enum logic [2:0] {
    flag_update_opcode = 3'h1,
    frame_time_compare_opcode = 3'h2,
    message_time_compare_opcode = 3'h4
  } seq_opcode_type;
endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  // s1 feeds only s2 so a metastable sample never reaches the decision
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// >>> tb/seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input wire logic clk,
  output logic seq_valid,
  output bc_flag_pkg::seq_opcode_type seq_opcode,
  output logic [15:0] seq_operand
);
  import bc_flag_pkg::*;
  initial begin
    seq_valid = 1'b0;
    seq_opcode = flag_update_opcode;
    seq_operand = 16'h0000;
  end
  task automatic issue(input seq_opcode_type op, input logic [15:0] opnd);
    @(posedge clk);
    seq_valid <= 1'b1;
    seq_opcode <= op;
    seq_operand <= opnd;
    @(posedge clk);
    seq_valid <= 1'b0;
    // operand is not held after the strobe, so show a changed value
    seq_operand <= ~opnd;
  endtask
endmodule
`default_nettype wire

// >>> tb/bc_condition_flag_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bc_condition_flag_logic_tb;
  import bc_flag_pkg::*;
  logic clk, arst_n, ce, run_pin, wr, rd, me, rr, sv;
  logic [15:0] addr, wd, rdata, cc, ftc, mtc, sopnd;
  logic [7:0] dly;
  seq_opcode_type sop;
  int failures = 0;
  int comparisons = 0;
  bc_condition_flag_logic dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
    .controller_run_enable(run_pin), .reg_addr(addr), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_wdata(wd), .reg_rdata(rdata), .seq_valid(sv),
    .seq_opcode(sop), .seq_operand(sopnd), .frame_time_count(ftc),
    .message_time_count(mtc), .message_end(me), .reply_received(rr),
    .reply_delay_us(dly), .condition_code(cc));
  seq_model seq_u (.clk(clk), .seq_valid(sv), .seq_opcode(sop), .seq_operand(sopnd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd16(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic msg(input logic r, input logic [7:0] d, input logic [15:0] e);
    @(posedge clk);
    me <= 1'b1;
    rr <= r;
    dly <= d;
    @(posedge clk);
    me <= 1'b0;
    #1 chk(cc, e);
  endtask
  task automatic seq(input seq_opcode_type op, input logic [15:0] o, input logic [15:0] e);
    seq_u.issue(op, o);
    #1 chk(cc, e);
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20us;
    failures++;
    report_and_stop();
  end
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    run_pin = 1'b1;
    {wr, rd, me, rr} = 4'h0;
    addr = 16'h0000;
    wd = 16'h0000;
    ftc = 16'h1234;
    mtc = 16'h0010;
    dly = 8'h00;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    // wait out reset release and the run pin synchroniser
    repeat (8) @(posedge clk);
    #1 chk(cc, 16'h0000);
    rd16(16'h0037, 16'h0000);
    wr16(16'h0037, 16'h00ff);
    rd16(16'h0037, 16'h0000);
    $display("test reset and gating done");
    wr16(16'h0000, 16'h1000);
    wr16(16'h0037, 16'h00a5);
    rd16(16'h0037, 16'h00a5);
    wr16(16'h0037, 16'hff0f);
    rd16(16'h0037, 16'h000a);
    wr16(16'h0037, 16'h0000);
    rd16(16'h0037, 16'h000a);
    @(posedge clk);
    run_pin <= 1'b0;
    repeat (5) @(posedge clk);
    wr16(16'h0037, 16'h00f0);
    rd16(16'h0037, 16'h000a);
    @(posedge clk);
    run_pin <= 1'b1;
    rd16(16'h0001, 16'h0000);
    $display("test host flags done");
    seq(flag_update_opcode, 16'h0303, 16'h0009);
    seq(frame_time_compare_opcode, 16'h1234, 16'h000a);
    seq(message_time_compare_opcode, 16'h0020, 16'h0009);
    seq(frame_time_compare_opcode, 16'h0001, 16'h0008);
    $display("test sequencer done");
    msg(1'b0, 8'h00, 16'h0108);
    msg(1'b1, 8'h0f, 16'h0008);
    msg(1'b1, 8'h10, 16'h0108);
    wr16(16'h0032, 16'h4000);
    msg(1'b1, 8'h14, 16'h0008);
    msg(1'b1, 8'h15, 16'h0108);
    wr16(16'h0032, 16'h8000);
    msg(1'b1, 8'h3a, 16'h0008);
    msg(1'b1, 8'h3b, 16'h0108);
    wr16(16'h0032, 16'hc000);
    msg(1'b1, 8'h10, 16'h0008);
    msg(1'b1, 8'h8b, 16'h0108);
    rd16(16'h0032, 16'hc000);
    rd16(16'h0000, 16'h1000);
    rd16(16'h0037, 16'h0108);
    $display("test no reply done");
    // a write while the clock enable is low must leave every flag frozen
    @(posedge clk);
    ce <= 1'b0;
    wr16(16'h0037, 16'h00ff);
    ce <= 1'b1;
    rd16(16'h0037, 16'h0108);
    $display("test clock enable done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(cc, 16'h0000);
    wr16(16'h0037, 16'h0001);
    rd16(16'h0037, 16'h0000);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
